// *** src/gate_timing_pkg.sv ***
// Constants and types shared by the intensifier gate trigger timing block
package gate_timing_pkg;

    // ------------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int CLK_KHZ         = 10000;

    // ------------------------------------------------------------------
    // Fixed timing (times as printed, counts derived)
    // ------------------------------------------------------------------
    localparam int DEAD_TIME_NS    = 500;
    localparam int DEAD_CYC        = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_SUM_NS      = 1000;
    localparam int MIN_SUM_CYC     = (MIN_SUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_EXP_NS    = 20;
    localparam int MON_LEAD_NS     = 60;
    localparam int MON_LEAD_CYC    = (MON_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_MON_NS    = 100;
    localparam int SHORT_MON_CYC   = SHORT_MON_NS / CLK_PERIOD_NS;
    localparam int SYS_DELAY_NS    = 300;
    localparam int SYS_DELAY_CYC   = (SYS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LED_HOLD_MS     = 100;
    localparam int LED_HOLD_CYC    = LED_HOLD_MS * CLK_KHZ;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int SET_W           = 16;
    localparam int LINK_CH         = 4;
    localparam int LED_CNT_W       = 24;
    localparam logic [SET_W-1:0] CNT_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_SOFTWARE   = 2'b00,
        SRC_ELECTRICAL = 2'b01,
        SRC_OPTICAL    = 2'b10,
        SRC_UNUSED     = 2'b11
    } trig_src_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SYS  = 3'b001,
        S_DLY1 = 3'b010,
        S_EXP1 = 3'b011,
        S_DLY2 = 3'b100,
        S_EXP2 = 3'b101,
        S_XFER = 3'b110
    } seq_state_t;

endpackage : gate_timing_pkg

// *** src/gate_trigger_timing.sv ***
// Trigger acceptance, exposure sequencing and gate/indicator outputs
//
// What this block does
// - Paired mode: second delay holds 500ns dead time
// - Fixed system and pulser delay always added
// - Trigger from software, electrical or optical input
// - Red trigger indicator lights on incoming electrical or optical trigger edge, not on software trigger
// - Four link inputs each show data activity
// - Gate monitor leads on and off by one 100ns cycle
// - Short exposures in single mode give fixed 100ns monitor pulse
// - Low gate inhibit suppresses photocathode on-time
// - Busy output; triggers ignored while busy
// - Busy polarity follows selected trigger edge
// - Transfer indicator high during image transfer
// - Green indicator shows link established
// - Red indicator shows DMA transfer activity
module gate_trigger_timing
    import gate_timing_pkg::*;
#(
    parameter int LED_HOLD = LED_HOLD_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Trigger sources and selection
    input  wire logic               sw_trigger,
    input  wire logic               external_trigger_in,
    input  wire logic               optical_trigger_in,
    input  wire logic [1:0]         trigger_source,
    input  wire logic               trigger_falling,
    // Exposure settings, in clock cycles; exposure 0 means below 20ns
    input  wire logic               paired_mode,
    input  wire logic [SET_W-1:0]   delay1,
    input  wire logic [SET_W-1:0]   exposure1,
    input  wire logic [SET_W-1:0]   delay2,
    input  wire logic [SET_W-1:0]   exposure2,
    input  wire logic [SET_W-1:0]   transfer_len,
    // Gate inhibit and link status pins
    input  wire logic               gate_inhibit_in_n,
    input  wire logic [LINK_CH-1:0] link_activity_in,
    input  wire logic               link_ok_in,
    input  wire logic               dma_active_in,
    // Gate and sequencing outputs
    output logic                    cathode_on,
    output logic                    gate_monitor,
    output logic                    busy_out,
    output logic                    transfer_out,
    output logic                    setting_invalid,
    // Indicators
    output logic                    trigger_led,
    output logic [LINK_CH-1:0]      link_led,
    output logic                    link_ok_led,
    output logic                    dma_led
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] ext_s_q, opt_s_q, inh_s_q, ok_s_q, dma_s_q;
    logic       sel_prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_s_q <= 2'h0;
            opt_s_q <= 2'h0;
            inh_s_q <= 2'h3;
            ok_s_q  <= 2'h0;
            dma_s_q <= 2'h0;
        end else begin
            ext_s_q <= {ext_s_q[0], external_trigger_in};
            opt_s_q <= {opt_s_q[0], optical_trigger_in};
            inh_s_q <= {inh_s_q[0], gate_inhibit_in_n};
            ok_s_q  <= {ok_s_q[0], link_ok_in};
            dma_s_q <= {dma_s_q[0], dma_active_in};
        end
    end

    // ------------------------------------------------------------------
    // Trigger selection and edge detection
    // ------------------------------------------------------------------
    logic sel_level, ext_edge, trig_event, invalid_d;
    seq_state_t state_q, state_d;

    always_comb begin
        unique case (trigger_source)
            SRC_ELECTRICAL: sel_level = ext_s_q[1];
            SRC_OPTICAL:    sel_level = opt_s_q[1];
            default:        sel_level = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_level;
        end
    end

    // Edge per selection; optical pulses shorter than a cycle may be missed
    assign ext_edge = trigger_falling ? (sel_prev_q & ~sel_level) : (~sel_prev_q & sel_level);

    assign trig_event = (state_q == S_IDLE) && !invalid_d &&
                        ((trigger_source == SRC_SOFTWARE) ? sw_trigger : ext_edge);

    // ------------------------------------------------------------------
    // Paired-mode setting check
    // ------------------------------------------------------------------
    logic [SET_W+1:0] sum_w;
    assign sum_w = {2'b00, delay1} + {2'b00, exposure1} + {2'b00, delay2};

    // Refuse sub-20ns exposures; dead time caps pulse rate at 2 MHz
    // Second delay must cover the dead time
    assign invalid_d = paired_mode &&
                       ((exposure1 == CNT_RESET) || (exposure2 == CNT_RESET) ||
                        (delay2 < SET_W'(DEAD_CYC)) || (sum_w < (SET_W+2)'(MIN_SUM_CYC)));

    // ------------------------------------------------------------------
    // Exposure sequencer
    // ------------------------------------------------------------------
    logic [SET_W-1:0] cnt_q, cnt_d;

    function automatic logic [SET_W-1:0] at_least_one(input logic [SET_W-1:0] v);
        at_least_one = (v == CNT_RESET) ? 16'h0001 : v;
    endfunction : at_least_one

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q - 16'h0001;
        unique case (state_q)
            S_IDLE: begin
                cnt_d = CNT_RESET;
                if (trig_event) begin
                    state_d = S_SYS;
                    cnt_d   = SET_W'(SYS_DELAY_CYC);
                end
            end
            S_SYS: if (cnt_q == 16'h0001) begin
                state_d = S_DLY1;
                cnt_d   = at_least_one(delay1);
            end
            S_DLY1: if (cnt_q == 16'h0001) begin
                state_d = S_EXP1;
                // Short exposure gives one 100ns cycle
                cnt_d   = (exposure1 == CNT_RESET) ? SET_W'(SHORT_MON_CYC) : exposure1;
            end
            S_EXP1: if (cnt_q == 16'h0001) begin
                state_d = paired_mode ? S_DLY2 : S_XFER;
                cnt_d   = paired_mode ? at_least_one(delay2) : at_least_one(transfer_len);
            end
            S_DLY2: if (cnt_q == 16'h0001) begin
                state_d = S_EXP2;
                cnt_d   = exposure2;
            end
            S_EXP2: if (cnt_q == 16'h0001) begin
                state_d = S_XFER;
                cnt_d   = at_least_one(transfer_len);
            end
            S_XFER: if (cnt_q == 16'h0001) state_d = S_IDLE;
            // Unused code falls back to idle, which clears the counter
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            cnt_q   <= CNT_RESET;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Gate monitor and photocathode drive
    // ------------------------------------------------------------------
    // Monitor high one cycle ahead of the cathode, both edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_monitor <= 1'b0;
            cathode_on   <= 1'b0;
        end else begin
            gate_monitor <= (state_d == S_EXP1) || (state_d == S_EXP2);
            // Inhibit pin gates the cathode, sampled after two flops
            cathode_on   <= gate_monitor && inh_s_q[1];
        end
    end

    // ------------------------------------------------------------------
    // Busy, transfer and setting status outputs
    // ------------------------------------------------------------------
    // Busy level inverted for falling-edge triggering
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_out        <= 1'b0;
            transfer_out    <= 1'b0;
            setting_invalid <= 1'b0;
        end else begin
            busy_out        <= (state_d != S_IDLE) ^ trigger_falling;
            transfer_out    <= (state_d == S_XFER);
            setting_invalid <= invalid_d;
        end
    end

    // ------------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------------
    logic [LED_CNT_W-1:0] led_cnt_q;

    // Stretch so a single trigger is visible
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_cnt_q   <= 24'h000000;
            trigger_led <= 1'b0;
        end else begin
            if (ext_edge) begin
                led_cnt_q <= LED_CNT_W'(LED_HOLD);
            end else if (led_cnt_q != 24'h000000) begin
                led_cnt_q <= led_cnt_q - 24'h000001;
            end
            trigger_led <= ext_edge || (led_cnt_q > 24'h000001);
        end
    end

    // One activity indicator per link channel
    for (genvar ch = 0; ch < LINK_CH; ch++) begin : g_link
        logic [1:0] act_s_q;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                act_s_q     <= 2'h0;
                link_led[ch] <= 1'b0;
            end else begin
                act_s_q     <= {act_s_q[0], link_activity_in[ch]};
                link_led[ch] <= act_s_q[1];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_ok_led <= 1'b0;
            dma_led     <= 1'b0;
        end else begin
            link_ok_led <= ok_s_q[1];
            dma_led     <= dma_s_q[1];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_exp1_end;
        (state_q == S_EXP1) && (cnt_q == 16'h0001) && paired_mode;
    endsequence
    a_dead_gap: assert property (@(posedge clk) disable iff (rst)
        s_exp1_end |=> !gate_monitor [*5])
        else $error("dead interval shorter than 500ns");
    a_lead_edge: assert property (@(posedge clk) disable iff (rst)
        $rose(gate_monitor) && inh_s_q[1] |=> $rose(cathode_on))
        else $error("cathode did not follow monitor by one cycle");
    a_tail_edge: assert property (@(posedge clk) disable iff (rst)
        $fell(gate_monitor) |=> !cathode_on)
        else $error("cathode stayed on after monitor fell");
    a_short_pulse: assert property (@(posedge clk) disable iff (rst)
        (state_q == S_DLY1) && (cnt_q == 16'h0001) && (exposure1 == CNT_RESET)
        |=> gate_monitor ##1 !gate_monitor)
        else $error("short exposure monitor pulse not one cycle");
    a_inhibit_gate: assert property (@(posedge clk) disable iff (rst)
        !inh_s_q[1] |=> !cathode_on)
        else $error("cathode on while inhibited");
    a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
        (state_q == S_XFER) && (cnt_q > 16'h0001) |=> (state_q == S_XFER))
        else $error("trigger accepted while busy");
    a_busy_polar: assert property (@(posedge clk) disable iff (rst)
        $stable(trigger_falling) && !$past(rst) && (state_q == S_IDLE) &&
        ($past(state_d) == S_IDLE) |-> (busy_out == trigger_falling))
        else $error("busy level wrong for edge selection");
    a_invalid_refuse: assert property (@(posedge clk) disable iff (rst)
        (state_q == S_IDLE) && invalid_d |=> (state_q == S_IDLE))
        else $error("invalid paired setting started a sequence");
    a_sys_delay: assert property (@(posedge clk) disable iff (rst)
        trig_event |=> (state_q == S_SYS) [*3] ##1 (state_q == S_DLY1))
        else $error("system delay not applied");
endmodule : gate_trigger_timing

// *** verification/trig_source_model.sv ***
// Model of the experiment equipment that drives trigger and gate inhibit pins
module trig_source_model
    import gate_timing_pkg::*;
(
    // Clock used to pace the pulses
    input  wire logic clk,
    // Trigger and inhibit pins
    output logic      external_trigger_in,
    output logic      optical_trigger_in,
    output logic      gate_inhibit_in_n
);
    timeunit 1ns;
    timeprecision 1ns;

    // Electrical pin is pulled to ground, so idle is low; no light is low too
    initial begin
        external_trigger_in = 1'b0;
        optical_trigger_in  = 1'b0;
        gate_inhibit_in_n   = 1'b1;
    end

    // Rising edge, held three cycles, far beyond 10ns
    task automatic pulse(input logic optical);
        @(posedge clk);
        #5;
        if (optical) begin
            optical_trigger_in = 1'b1;
        end else begin
            external_trigger_in = 1'b1;
        end
        repeat (3) @(posedge clk);
        #5;
        optical_trigger_in  = 1'b0;
        external_trigger_in = 1'b0;
    endtask : pulse

    // Inhibit only driven while exposure is above 20ns
    task automatic inhibit(input logic on, input logic [SET_W-1:0] exposure);
        gate_inhibit_in_n = (exposure != 16'h0000) ? ~on : 1'b1;
    endtask : inhibit
endmodule : trig_source_model

// *** verification/testbench.sv ***
// Self-checking testbench for the gate trigger timing block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import gate_timing_pkg::*;

    // ----------
    // Signals
    // ----------
    logic               clk              = 1'b0;
    logic               rst              = 1'b1;
    logic               sw_trigger       = 1'b0;
    logic [1:0]         trigger_source   = 2'b00;
    logic               trigger_falling  = 1'b0;
    logic               paired_mode      = 1'b0;
    logic [SET_W-1:0]   delay1           = 16'h0002;
    logic [SET_W-1:0]   exposure1        = 16'h0003;
    logic [SET_W-1:0]   delay2           = 16'h0005;
    logic [SET_W-1:0]   exposure2        = 16'h0002;
    logic [SET_W-1:0]   transfer_len     = 16'h0002;
    logic [LINK_CH-1:0] link_activity_in = 4'h0;
    logic               link_ok_in       = 1'b0;
    logic               dma_active_in    = 1'b0;
    logic               external_trigger_in, optical_trigger_in, gate_inhibit_in_n;
    logic               cathode_on, gate_monitor, busy_out, transfer_out;
    logic               setting_invalid, trigger_led, link_ok_led, dma_led, pmon;
    logic [LINK_CH-1:0] link_led;
    int                 fail_count       = 0;
    int                 comparisons      = 0;
    int                 kk, first, cfirst, lrise, mon_n, rises, cath_n, xfer_n, busy_n, led_n;

    always #50 clk = ~clk;

    // Short LED hold keeps the indicator checks brief
    gate_trigger_timing #(.LED_HOLD(8)) u_dut (
        .clk(clk), .rst(rst), .sw_trigger(sw_trigger),
        .external_trigger_in(external_trigger_in), .optical_trigger_in(optical_trigger_in),
        .trigger_source(trigger_source), .trigger_falling(trigger_falling),
        .paired_mode(paired_mode), .delay1(delay1), .exposure1(exposure1), .delay2(delay2),
        .exposure2(exposure2), .transfer_len(transfer_len),
        .gate_inhibit_in_n(gate_inhibit_in_n), .link_activity_in(link_activity_in),
        .link_ok_in(link_ok_in), .dma_active_in(dma_active_in), .cathode_on(cathode_on),
        .gate_monitor(gate_monitor), .busy_out(busy_out), .transfer_out(transfer_out),
        .setting_invalid(setting_invalid), .trigger_led(trigger_led), .link_led(link_led),
        .link_ok_led(link_ok_led), .dma_led(dma_led)
    );

    trig_source_model u_src (
        .clk(clk), .external_trigger_in(external_trigger_in),
        .optical_trigger_in(optical_trigger_in), .gate_inhibit_in_n(gate_inhibit_in_n)
    );

    // ----------
    // Helpers
    // ----------
    task automatic chk(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk

    task automatic results;
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick

    task automatic setup(input logic pm, input logic tf, input logic [SET_W-1:0] d1, e1, d2);
        paired_mode     = pm;
        trigger_falling = tf;
        delay1          = d1;
        exposure1       = e1;
        delay2          = d2;
        tick(2);
        kk = 0;
        {mon_n, rises, cath_n, xfer_n, busy_n, led_n} = '0;
        {first, cfirst, lrise} = {-32'sd1, -32'sd1, -32'sd1};
    endtask : setup

    // Counts the outputs once per cycle, just after each edge has settled
    task automatic measure(input int n);
        repeat (n) begin
            pmon = gate_monitor;
            tick(1);
            kk++;
            if (gate_monitor === 1'b1 && pmon !== 1'b1) begin
                rises++;
                lrise = kk;
                if (first < 0) first = kk;
            end
            if (cathode_on === 1'b1 && cfirst < 0) cfirst = kk;
            mon_n  += int'(gate_monitor === 1'b1);
            cath_n += int'(cathode_on === 1'b1);
            xfer_n += int'(transfer_out === 1'b1);
            busy_n += int'(busy_out === ~trigger_falling);
            led_n  += int'(trigger_led === 1'b1);
        end
    endtask : measure

    task automatic fire_sw;
        sw_trigger = 1'b1;
        tick(1);
        sw_trigger = 1'b0;
    endtask : fire_sw

    // ----------
    // Scenarios
    // ----------
    task automatic t_single(input logic [SET_W-1:0] e, input int mon);
        setup(1'b0, 1'b0, 16'h0002, e, 16'h0005);
        fire_sw();
        measure(25);
        chk(first == SYS_DELAY_CYC + 2, "monitor start");
        chk(mon == mon_n && rises == 1, "monitor width");
        if (e != 16'h0000) begin
            chk(cfirst == first + MON_LEAD_CYC && cath_n == mon, "cathode");
            chk(xfer_n == 2, "transfer width");
            chk(busy_n == SYS_DELAY_CYC + 2 + 3 + 2 - 1, "busy span");
        end
    endtask : t_single

    task automatic t_paired;
        // Closely spaced pair, sum exactly ten cycles
        setup(1'b1, 1'b1, 16'h0002, 16'h0003, 16'h0005);
        chk(setting_invalid === 1'b0, "valid pair flagged");
        fire_sw();
        measure(30);
        chk(rises == 2 && mon_n == 5 && cath_n == 5, "pair exposures");
        chk(lrise - first == 3 + DEAD_CYC, "pair spacing");
        chk(busy_n == SYS_DELAY_CYC + 2 + 3 + 5 + 2 + 2 - 1, "pair busy");
        chk(busy_out === 1'b1, "falling mode ready level");
    endtask : t_paired

    task automatic t_invalid;
        logic [SET_W-1:0] d1v [3] = '{16'h0002, 16'h0002, 16'h0001};
        logic [SET_W-1:0] e1v [3] = '{16'h0003, 16'h0000, 16'h0001};
        logic [SET_W-1:0] d2v [3] = '{16'h0004, 16'h0005, 16'h0005};
        for (int i = 0; i < 3; i++) begin
            setup(1'b1, 1'b0, d1v[i], e1v[i], d2v[i]);
            chk(setting_invalid === 1'b1, "bad pair not flagged");
            fire_sw();
            measure(20);
            chk(rises == 0 && busy_n == 0, "bad pair started");
        end
    endtask : t_invalid

    task automatic t_inhibit;
        setup(1'b0, 1'b0, 16'h0002, 16'h0003, 16'h0005);
        u_src.inhibit(1'b1, exposure1);
        fire_sw();
        measure(20);
        chk(mon_n == 3 && cath_n == 0, "inhibit ignored");
        u_src.inhibit(1'b0, exposure1);
    endtask : t_inhibit

    task automatic t_sources;
        for (int s = 1; s < 3; s++) begin
            trigger_source = s[1:0];
            setup(1'b0, 1'b0, 16'h0008, 16'h0003, 16'h0005);
            u_src.pulse(s == 2);
            measure(2);
            u_src.pulse(s == 2);
            measure(30);
            chk(rises == 1 && led_n > 0, "selected pin or busy refusal");
            setup(1'b0, 1'b0, 16'h0008, 16'h0003, 16'h0005);
            u_src.pulse(s == 1);
            measure(20);
            chk(rises == 0 && led_n == 0, "unselected pin taken");
        end
        // Falling-edge selection: the trailing pin edge starts the sequence
        trigger_source = 2'b01;
        setup(1'b0, 1'b1, 16'h0002, 16'h0003, 16'h0005);
        u_src.pulse(1'b0);
        measure(20);
        chk(rises == 1 && first == 3 + SYS_DELAY_CYC + 2, "falling edge trigger");
        chk(busy_n == SYS_DELAY_CYC + 2 + 3 + 2, "falling busy span");
        trigger_source = 2'b00;
    endtask : t_sources

    task automatic t_links;
        for (int i = 0; i < 2; i++) begin
            link_activity_in = (i == 0) ? 4'hA : 4'h5;
            link_ok_in       = (i == 0);
            dma_active_in    = (i == 0);
            tick(4);
            chk(link_led === link_activity_in, "link leds");
            chk(link_ok_led === link_ok_in, "link ok led");
            chk(dma_led === dma_active_in, "dma led");
        end
    endtask : t_links

    initial begin
        tick(12);
        chk(busy_out === 1'b0 && gate_monitor === 1'b0, "reset outputs");
        rst = 1'b0;
        tick(2);
        chk(busy_out === trigger_falling, "idle busy level");
        t_single(16'h0003, 3);
        t_single(16'h0000, SHORT_MON_CYC);
        t_paired();
        t_invalid();
        t_inhibit();
        t_sources();
        t_links();
        results();
    end
endmodule : testbench
